//--- include/vmd_defines.svh
// Opcode, field, address and reset constants for the vector data-move decoder.
`ifndef VMD_DEFINES_SVH
`define VMD_DEFINES_SVH

// ==========================================================
// First-word opcodes
`define VMD_OP_HALF_STORE    16'he218
`define VMD_OP_HALF_LOAD     16'he2c9
`define VMD_OP_WORD_STORE_GP 16'he204
`define VMD_OP_WORD_STORE_ST 16'he20d
`define VMD_OP_WORD_STORE_VT 16'he205
`define VMD_OP_WORD_LOAD_GP  16'he3f0
`define VMD_OP_WORD_LOAD_VT  16'he3f1
`define VMD_OP_WORD_LOAD_ST  16'he2b0
`define VMD_OP_REG_MOVE      16'he6f2
`define VMD_OP_ABS_WRITE     8'hbd
`define VMD_OP_ABS_READ      8'hbf

// ==========================================================
// Instruction-word and data-word fields and their fixed values
`define VMD_F_SEL        15:12
`define VMD_F_REG        11:8
`define VMD_F_HIGHBYTE   15:8
`define VMD_F_VT_PAD     15:9
`define VMD_F_VT_IDX     8
`define VMD_F_MV_DST     7:4
`define VMD_F_MV_SRC     3:0
`define VMD_F_OPND       7:0
`define VMD_F_ABS_OP     15:8
`define VMD_F_HI         31:16
`define VMD_F_LO         15:0
`define VMD_F_ABS_WORD   15:1
`define VMD_F_ABS_HALF   0
`define VMD_F_IDX_LOW    3:0
`define VMD_HALF_SEL_HIGH 4'h1
`define VMD_HALF_SEL_LOW  4'h0
`define VMD_MOVE_TAG      8'h02
`define VMD_ZERO_BYTE     8'h00
`define VMD_VT_PAD_ZERO   7'h00
`define VMD_HALF_PAD      16'h0000
`define VMD_MASK_HIGH     2'b10
`define VMD_MASK_LOW      2'b01
`define VMD_MASK_FULL     2'b11
`define VMD_MASK_NONE     2'b00

// ==========================================================
// Register counts and absolute-address word indices
`define VMD_NUM_GP         4'h9
`define VMD_NUM_VT         2
`define VMD_ABS_IDX_GP_END 15'h0009
`define VMD_ABS_IDX_VT0    15'h0009
`define VMD_ABS_IDX_VT1    15'h000a
`define VMD_ABS_IDX_ST     15'h000b

// ==========================================================
// Reset values
`define VMD_STATUS_RESET 32'h0000_0000
`define VMD_WORD_ZERO    32'h0000_0000

`endif

//--- include/vmd_pkg.sv
// Shared types for the vector data-move decoder.
`include "vmd_defines.svh"
package vmd_pkg;
    typedef logic [31:0] vmd_word_t;

    typedef enum logic [2:0] {
        VMD_IDLE   = 3'b001,
        VMD_ABS_WR = 3'b010,
        VMD_ABS_RD = 3'b100
    } vmd_phase_e;

    typedef struct packed {
        logic [`VMD_NUM_GP-1:0][31:0] gp;
        logic [`VMD_NUM_VT-1:0][31:0] vt;
        vmd_word_t                    status;
    } vmd_rf_s;

    typedef struct packed {
        vmd_phase_e  phase;
        logic        busy;
        logic [15:0] abs_addr;
        vmd_word_t   abs_data;
        logic [7:0]  loc_sel;
        logic        loc_wr;
        vmd_word_t   loc_data;
        logic        mem_wr;
        logic        mem_wr32;
        vmd_word_t   mem_wdata;
        logic [7:0]  mem_opnd;
    } vmd_top_s;
endpackage

//--- include/vmd_rf_if.sv
// Write and read ports between the decoder and the vector register file.
`timescale 1ns/1ps
interface vmd_rf_if;
    logic        gp_we;
    logic [3:0]  gp_widx;
    logic [1:0]  gp_wmask;
    logic [31:0] gp_wdata;
    logic [3:0]  gp_ridx;
    logic [31:0] gp_rdata;
    logic        vt_we;
    logic        vt_widx;
    logic [31:0] vt_wdata;
    logic        vt_ridx;
    logic [31:0] vt_rdata;
    logic        st_we;
    logic [31:0] st_wdata;
    logic [31:0] status;

    modport decoder (
        output gp_we, gp_widx, gp_wmask, gp_wdata, gp_ridx,
        output vt_we, vt_widx, vt_wdata, vt_ridx, st_we, st_wdata,
        input  gp_rdata, vt_rdata, status
    );
    modport owner (
        input  gp_we, gp_widx, gp_wmask, gp_wdata, gp_ridx,
        input  vt_we, vt_widx, vt_wdata, vt_ridx, st_we, st_wdata,
        output gp_rdata, vt_rdata, status
    );
endinterface

//--- rtl/vmd_regfile.sv
// Vector general purpose, transition-bit and status registers.
`timescale 1ns/1ps
`include "vmd_defines.svh"
module vmd_regfile import vmd_pkg::*; (
    input  wire logic clk_in,
    input  wire logic rst_in,
    vmd_rf_if.owner   rf
);
    vmd_rf_s st;
    vmd_rf_s next_st;

    // ==========================================================
    // Register update
    // An index past the last register is dropped here as well, so no
    // caller can corrupt a neighbour by a bad field.
    always_comb begin
        next_st = st;
        if (rf.gp_we && rf.gp_widx < `VMD_NUM_GP) begin
            if (rf.gp_wmask[1]) begin
                next_st.gp[rf.gp_widx][`VMD_F_HI] = rf.gp_wdata[`VMD_F_HI];
            end
            if (rf.gp_wmask[0]) begin
                next_st.gp[rf.gp_widx][`VMD_F_LO] = rf.gp_wdata[`VMD_F_LO];
            end
        end
        if (rf.vt_we) begin
            next_st.vt[rf.vt_widx] = rf.vt_wdata;
        end
        if (rf.st_we) begin
            next_st.status = rf.st_wdata;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '{status: `VMD_STATUS_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Read ports
    assign rf.gp_rdata = (rf.gp_ridx < `VMD_NUM_GP) ? st.gp[rf.gp_ridx] : `VMD_WORD_ZERO;
    assign rf.vt_rdata = st.vt[rf.vt_ridx];
    assign rf.status   = st.status;
endmodule

//--- rtl/vmd_decode.sv
// Decode and execution of the vector coprocessor data-move instructions.
`timescale 1ns/1ps
`include "vmd_defines.svh"
module vmd_decode import vmd_pkg::*; (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        INSN_VALID_IN,
    input  wire logic [15:0] INSN_LSW_IN,
    input  wire logic [15:0] INSN_MSW_IN,
    input  wire logic [31:0] MEM_RDATA_IN,
    input  wire logic [31:0] CPU_LOC_IN,
    output logic             BUSY_OUT,
    output logic             MEM_WR_OUT,
    output logic             MEM_WR32_OUT,
    output logic [31:0]      MEM_WDATA_OUT,
    output logic [7:0]       MEM_OPND_OUT,
    output logic             LOC_WR_OUT,
    output logic [7:0]       LOC_SEL_OUT,
    output logic [31:0]      LOC_DATA_OUT,
    output logic [31:0]      STATUS_OUT
);
    vmd_top_s st;
    vmd_top_s next_st;
    vmd_rf_if rf ();

    vmd_regfile u_regfile (
        .clk_in (MCLK_IN),
        .rst_in (RST_IN),
        .rf     (rf)
    );

    // ==========================================================
    // Instruction field decode
    logic        take;
    logic [15:0] lsw;
    logic [15:0] msw;
    logic        reg_ok;
    logic        half_ok;
    logic        half_hi;
    logic        vt_ok;
    logic        dec_hst;
    logic        dec_hld;
    logic        dec_wst_gp;
    logic        dec_wst_st;
    logic        dec_wst_vt;
    logic        dec_wld_gp;
    logic        dec_wld_vt;
    logic        dec_wld_st;
    logic        dec_move;
    logic        dec_abs_wr;
    logic        dec_abs_rd;
    logic [14:0] abs_idx;
    logic        abs_even;

    // A new instruction is only taken while no absolute transfer is open.
    assign take    = INSN_VALID_IN && (st.phase == VMD_IDLE);
    assign lsw     = INSN_LSW_IN;
    assign msw     = INSN_MSW_IN;
    assign reg_ok  = msw[`VMD_F_REG] < `VMD_NUM_GP;
    assign half_hi = msw[`VMD_F_SEL] == `VMD_HALF_SEL_HIGH;
    assign half_ok = half_hi || (msw[`VMD_F_SEL] == `VMD_HALF_SEL_LOW);
    assign vt_ok   = msw[`VMD_F_VT_PAD] == `VMD_VT_PAD_ZERO;

    assign dec_hst    = take && lsw == `VMD_OP_HALF_STORE && half_ok && reg_ok;
    assign dec_hld    = take && lsw == `VMD_OP_HALF_LOAD && half_ok && reg_ok;
    assign dec_wst_gp = take && lsw == `VMD_OP_WORD_STORE_GP
                        && msw[`VMD_F_SEL] == `VMD_HALF_SEL_LOW && reg_ok;
    assign dec_wst_st = take && lsw == `VMD_OP_WORD_STORE_ST
                        && msw[`VMD_F_HIGHBYTE] == `VMD_ZERO_BYTE;
    assign dec_wst_vt = take && lsw == `VMD_OP_WORD_STORE_VT && vt_ok;
    assign dec_wld_gp = take && lsw == `VMD_OP_WORD_LOAD_GP
                        && msw[`VMD_F_SEL] == `VMD_HALF_SEL_LOW && reg_ok;
    assign dec_wld_vt = take && lsw == `VMD_OP_WORD_LOAD_VT && vt_ok;
    assign dec_wld_st = take && lsw == `VMD_OP_WORD_LOAD_ST
                        && msw[`VMD_F_HIGHBYTE] == `VMD_ZERO_BYTE;
    assign dec_move   = take && lsw == `VMD_OP_REG_MOVE
                        && msw[`VMD_F_HIGHBYTE] == `VMD_MOVE_TAG
                        && msw[`VMD_F_MV_DST] < `VMD_NUM_GP
                        && msw[`VMD_F_MV_SRC] < `VMD_NUM_GP;
    assign dec_abs_wr = take && lsw[`VMD_F_ABS_OP] == `VMD_OP_ABS_WRITE;
    assign dec_abs_rd = take && lsw[`VMD_F_ABS_OP] == `VMD_OP_ABS_READ;

    // The 16-bit absolute address counts half-words, so a register is a pair.
    assign abs_idx  = st.abs_addr[`VMD_F_ABS_WORD];
    assign abs_even = ~st.abs_addr[`VMD_F_ABS_HALF];

    // ==========================================================
    // Next state and register file strobes
    always_comb begin
        next_st        = st;
        next_st.mem_wr = 1'b0;
        next_st.loc_wr = 1'b0;
        rf.gp_we       = 1'b0;
        rf.gp_widx     = msw[`VMD_F_REG];
        rf.gp_wmask    = `VMD_MASK_NONE;
        rf.gp_wdata    = MEM_RDATA_IN;
        rf.gp_ridx     = msw[`VMD_F_REG];
        rf.vt_we       = 1'b0;
        rf.vt_widx     = msw[`VMD_F_VT_IDX];
        rf.vt_wdata    = MEM_RDATA_IN;
        rf.vt_ridx     = msw[`VMD_F_VT_IDX];
        rf.st_we       = 1'b0;
        rf.st_wdata    = MEM_RDATA_IN;
        unique case (st.phase)
            VMD_IDLE: begin
                next_st.mem_opnd = msw[`VMD_F_OPND];
                if (dec_hst) begin
                    next_st.mem_wr   = 1'b1;
                    next_st.mem_wr32 = 1'b0;
                    if (half_hi) begin
                        next_st.mem_wdata = {`VMD_HALF_PAD, rf.gp_rdata[`VMD_F_HI]};
                    end else begin
                        next_st.mem_wdata = {`VMD_HALF_PAD, rf.gp_rdata[`VMD_F_LO]};
                    end
                end
                if (dec_hld) begin
                    rf.gp_we = 1'b1;
                    if (half_hi) begin
                        rf.gp_wmask = `VMD_MASK_HIGH;
                        rf.gp_wdata = {MEM_RDATA_IN[`VMD_F_LO], `VMD_HALF_PAD};
                    end else begin
                        rf.gp_wmask = `VMD_MASK_LOW;
                        rf.gp_wdata = {`VMD_HALF_PAD, MEM_RDATA_IN[`VMD_F_LO]};
                    end
                end
                if (dec_wst_gp) begin
                    next_st.mem_wr    = 1'b1;
                    next_st.mem_wr32  = 1'b1;
                    next_st.mem_wdata = rf.gp_rdata;
                end
                if (dec_wst_st) begin
                    next_st.mem_wr    = 1'b1;
                    next_st.mem_wr32  = 1'b1;
                    next_st.mem_wdata = rf.status;
                end
                if (dec_wst_vt) begin
                    next_st.mem_wr    = 1'b1;
                    next_st.mem_wr32  = 1'b1;
                    next_st.mem_wdata = rf.vt_rdata;
                end
                if (dec_wld_gp) begin
                    rf.gp_we    = 1'b1;
                    rf.gp_wmask = `VMD_MASK_FULL;
                end
                if (dec_wld_vt) begin
                    rf.vt_we = 1'b1;
                end
                if (dec_wld_st) begin
                    rf.st_we = 1'b1;
                end
                // The read port is steered to the source before the write is
                // formed, so a move onto itself simply rewrites the old value.
                if (dec_move) begin
                    rf.gp_ridx  = msw[`VMD_F_MV_SRC];
                    rf.gp_widx  = msw[`VMD_F_MV_DST];
                    rf.gp_we    = 1'b1;
                    rf.gp_wmask = `VMD_MASK_FULL;
                    rf.gp_wdata = rf.gp_rdata;
                end
                if (dec_abs_wr || dec_abs_rd) begin
                    next_st.abs_addr = msw;
                    next_st.abs_data = CPU_LOC_IN;
                    next_st.loc_sel  = lsw[`VMD_F_OPND];
                    next_st.phase    = dec_abs_wr ? VMD_ABS_WR : VMD_ABS_RD;
                end
            end
            VMD_ABS_WR: begin
                // Write protection is not consulted on this path at all.
                // The status word has no absolute write so that only the
                // status load can change it.
                rf.gp_widx  = abs_idx[`VMD_F_IDX_LOW];
                rf.gp_wmask = `VMD_MASK_FULL;
                rf.gp_wdata = st.abs_data;
                rf.vt_widx  = abs_idx == `VMD_ABS_IDX_VT1;
                rf.vt_wdata = st.abs_data;
                if (abs_even && abs_idx < `VMD_ABS_IDX_GP_END) begin
                    rf.gp_we = 1'b1;
                end
                if (abs_even && (abs_idx == `VMD_ABS_IDX_VT0
                                 || abs_idx == `VMD_ABS_IDX_VT1)) begin
                    rf.vt_we = 1'b1;
                end
                next_st.phase = VMD_IDLE;
            end
            VMD_ABS_RD: begin
                rf.gp_ridx       = abs_idx[`VMD_F_IDX_LOW];
                rf.vt_ridx       = abs_idx == `VMD_ABS_IDX_VT1;
                next_st.loc_wr   = 1'b1;
                next_st.loc_data = `VMD_WORD_ZERO;
                if (abs_even && abs_idx < `VMD_ABS_IDX_GP_END) begin
                    next_st.loc_data = rf.gp_rdata;
                end else if (abs_even && (abs_idx == `VMD_ABS_IDX_VT0
                                          || abs_idx == `VMD_ABS_IDX_VT1)) begin
                    next_st.loc_data = rf.vt_rdata;
                end else if (abs_even && abs_idx == `VMD_ABS_IDX_ST) begin
                    next_st.loc_data = rf.status;
                end
                next_st.phase = VMD_IDLE;
            end
            default: begin
                next_st.phase = VMD_IDLE;
            end
        endcase
        next_st.busy = next_st.phase != VMD_IDLE;
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st <= '{phase: VMD_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign BUSY_OUT      = st.busy;
    assign MEM_WR_OUT    = st.mem_wr;
    assign MEM_WR32_OUT  = st.mem_wr32;
    assign MEM_WDATA_OUT = st.mem_wdata;
    assign MEM_OPND_OUT  = st.mem_opnd;
    assign LOC_WR_OUT    = st.loc_wr;
    assign LOC_SEL_OUT   = st.loc_sel;
    assign LOC_DATA_OUT  = st.loc_data;
    assign STATUS_OUT    = rf.status;

    // ==========================================================
    // Checks
    a_half_store_high: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_hst && half_hi |=> MEM_WR_OUT && !MEM_WR32_OUT
            && MEM_WDATA_OUT[`VMD_F_LO] == $past(rf.gp_rdata[`VMD_F_HI]))
        else $error("High half store sent wrong data.");

    a_half_store_low: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_hst && !half_hi |=> MEM_WR_OUT
            && MEM_WDATA_OUT[`VMD_F_LO] == $past(rf.gp_rdata[`VMD_F_LO]))
        else $error("Low half store sent wrong data.");

    a_half_load_high: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_hld && half_hi |-> rf.gp_we && rf.gp_wmask == `VMD_MASK_HIGH
            && rf.gp_wdata[`VMD_F_HI] == MEM_RDATA_IN[`VMD_F_LO])
        else $error("High half load did not target the upper half.");

    a_half_load_low: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_hld && !half_hi |-> rf.gp_we && rf.gp_wmask == `VMD_MASK_LOW)
        else $error("Low half load did not target the lower half.");

    a_abs_write_span: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_abs_wr |=> BUSY_OUT ##1 !BUSY_OUT)
        else $error("Absolute write did not span two cycles.");

    a_abs_read_data: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_abs_rd |=> !LOC_WR_OUT ##1 LOC_WR_OUT && !BUSY_OUT)
        else $error("Absolute read answered at the wrong cycle.");

    a_word_store: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_wst_gp |=> MEM_WR_OUT && MEM_WR32_OUT && MEM_WDATA_OUT == $past(rf.gp_rdata))
        else $error("Word store sent wrong data.");

    a_vt_store: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_wst_vt |=> MEM_WR32_OUT && MEM_WDATA_OUT == $past(rf.vt_rdata))
        else $error("Transition store sent wrong data.");

    a_status_kept: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        !dec_wld_st |=> $stable(STATUS_OUT))
        else $error("Status changed without a status load.");

    a_move_copy: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_move |-> rf.gp_we && rf.gp_widx == msw[`VMD_F_MV_DST]
            && rf.gp_ridx == msw[`VMD_F_MV_SRC] && rf.gp_wdata == rf.gp_rdata)
        else $error("Register move copied the wrong register.");

    a_reserved_index: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        take && !reg_ok && lsw != `VMD_OP_REG_MOVE
            && lsw[`VMD_F_ABS_OP] != `VMD_OP_ABS_WRITE |-> !rf.gp_we)
        else $error("Reserved register index caused a write.");

    a_single_cycle: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_hst || dec_wst_gp || dec_wst_st || dec_move |=> !BUSY_OUT)
        else $error("Single-cycle move stalled the decoder.");

    // The status, load, absolute write and location checks below compare data with its source,
    // so a decode that writes the wrong word is caught as well as one that writes nothing.
    a_status_store: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_wst_st |=> MEM_WR_OUT && MEM_WR32_OUT && MEM_WDATA_OUT == $past(STATUS_OUT))
        else $error("Status store sent wrong data.");

    a_status_load: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_wld_st |=> STATUS_OUT == $past(MEM_RDATA_IN))
        else $error("Status load did not take the memory word.");

    a_word_load: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_wld_gp |-> rf.gp_we && rf.gp_widx == msw[`VMD_F_REG]
            && rf.gp_wmask == `VMD_MASK_FULL && rf.gp_wdata == MEM_RDATA_IN)
        else $error("Word load did not fill the whole register.");

    a_vt_load: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_wld_vt |-> rf.vt_we && rf.vt_widx == msw[`VMD_F_VT_IDX]
            && rf.vt_wdata == MEM_RDATA_IN)
        else $error("Transition load did not take the memory word.");

    a_abs_write_reg: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_abs_wr && !msw[`VMD_F_ABS_HALF] && msw[`VMD_F_ABS_WORD] < `VMD_ABS_IDX_GP_END
            |=> rf.gp_we && rf.gp_wdata == $past(CPU_LOC_IN))
        else $error("Absolute write did not carry the CPU value.");

    a_half_store_pad: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_hst |=> !MEM_WR32_OUT && MEM_WDATA_OUT[`VMD_F_HI] == `VMD_HALF_PAD)
        else $error("Half store was not a padded 16-bit store.");

    a_reserved_move: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        take && lsw == `VMD_OP_REG_MOVE && !dec_move |-> !rf.gp_we)
        else $error("Reserved move encoding caused a write.");

    a_loc_select: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_abs_rd |=> ##1 LOC_SEL_OUT == $past(INSN_LSW_IN[`VMD_F_OPND], 2))
        else $error("Absolute read named the wrong CPU location.");

    a_odd_read_zero: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        dec_abs_rd && msw[`VMD_F_ABS_HALF]
            |=> ##1 LOC_WR_OUT && LOC_DATA_OUT == `VMD_WORD_ZERO)
        else $error("Odd absolute read did not return zero.");
endmodule

//--- dv/vmd_host_mem.sv
// Host data memory model that answers operand reads and takes vector stores.
`timescale 1ns/1ps
module vmd_host_mem (
    input  wire logic        clk_in,
    input  wire logic [7:0]  rd_opnd_in,
    input  wire logic        wr_in,
    input  wire logic        wr32_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [7:0]  wr_opnd_in,
    output logic      [31:0] rdata_out
);
    // ==========================================================
    // Storage
    logic [31:0] mem [256];
    logic [31:0] merged;
    // A store still on the bus is forwarded, so a load right behind it sees the new word.
    assign merged = wr32_in ? wdata_in : {mem[wr_opnd_in][31:16], wdata_in[15:0]};
    assign rdata_out = (wr_in && wr_opnd_in == rd_opnd_in) ? merged : mem[rd_opnd_in];
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem[wr_opnd_in] <= merged;
        end
    end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the vector data-move decoder.
`timescale 1ns/1ps
`define VMD_CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
end
module testbench;
    // ==========================================================
    // Signals and model state
    logic clk = 0, rst = 1, valid = 0, busy, mem_wr, mem_wr32, loc_wr;
    logic [15:0] lsw = 0, msw = 0;
    logic [31:0] cpu_loc = 0, mem_rdata, mem_wdata, loc_data, status;
    logic [7:0]  mem_opnd, loc_sel;
    logic [31:0] gp [9], vt [2], st, bm [256], r;
    logic [15:0] m;
    logic [15:0] ops [9] = '{16'he218, 16'he2c9, 16'he204, 16'he20d, 16'he205,
                             16'he3f0, 16'he3f1, 16'he2b0, 16'he6f2};
    int errors = 0, n_tests = 0, k;
    always #2.5 clk = ~clk;
    vmd_decode DUT (.MCLK_IN(clk), .RST_IN(rst), .INSN_VALID_IN(valid), .INSN_LSW_IN(lsw),
        .INSN_MSW_IN(msw), .MEM_RDATA_IN(mem_rdata), .CPU_LOC_IN(cpu_loc), .BUSY_OUT(busy),
        .MEM_WR_OUT(mem_wr), .MEM_WR32_OUT(mem_wr32), .MEM_WDATA_OUT(mem_wdata),
        .MEM_OPND_OUT(mem_opnd), .LOC_WR_OUT(loc_wr), .LOC_SEL_OUT(loc_sel),
        .LOC_DATA_OUT(loc_data), .STATUS_OUT(status));
    vmd_host_mem host (.clk_in(clk), .rd_opnd_in(msw[7:0]), .wr_in(mem_wr),
        .wr32_in(mem_wr32), .wdata_in(mem_wdata), .wr_opnd_in(mem_opnd),
        .rdata_out(mem_rdata));
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Valid is low but the word would be a store: nothing may come out.
    task automatic idle(input int n);
        valid = 0;
        lsw = 16'he204;
        repeat (n) begin
            @(posedge clk);
            #1;
            `VMD_CHK("idle", 1'b0, mem_wr)
        end
    endtask
    task automatic op(input logic [15:0] l, input logic [15:0] mm);
        int a;
        int d;
        logic s;
        logic h;
        logic [31:0] w;
        logic [31:0] rd;
        a = mm[11:8];
        d = mm[7:4];
        s = 0;
        h = 1;
        w = '0;
        rd = bm[mm[7:0]];
        valid = 1;
        lsw = l;
        msw = mm;
        case (l)
            16'he218: if (a < 9 && mm[15:13] == 0) begin
                s = 1;
                h = 0;
                w = mm[12] ? {16'h0, gp[a][31:16]} : {16'h0, gp[a][15:0]};
            end
            16'he2c9: if (a < 9 && mm[15:13] == 0) begin
                if (mm[12]) gp[a][31:16] = rd[15:0];
                else gp[a][15:0] = rd[15:0];
            end
            16'he204: if (a < 9 && mm[15:12] == 0) begin
                s = 1;
                w = gp[a];
            end
            16'he20d: if (mm[15:8] == 0) begin
                s = 1;
                w = st;
            end
            16'he205: if (mm[15:9] == 0) begin
                s = 1;
                w = vt[mm[8]];
            end
            16'he3f0: if (a < 9 && mm[15:12] == 0) gp[a] = rd;
            16'he3f1: if (mm[15:9] == 0) vt[mm[8]] = rd;
            16'he2b0: if (mm[15:8] == 0) st = rd;
            16'he6f2: if (mm[15:8] == 2 && mm[3:0] < 9 && d < 9) gp[d] = gp[mm[3:0]];
            default: ;
        endcase
        @(posedge clk);
        #1;
        `VMD_CHK("store", s, mem_wr)
        if (s) begin
            `VMD_CHK("wdata", w, mem_wdata)
            `VMD_CHK("wr32", h, mem_wr32)
            `VMD_CHK("opnd", mm[7:0], mem_opnd)
            bm[mm[7:0]] = h ? w : {bm[mm[7:0]][31:16], w[15:0]};
        end
        `VMD_CHK("status", st, status)
    endtask
    task automatic abs_op(input logic wr, input logic [7:0] sel, input logic [15:0] ad);
        int a;
        logic [31:0] v;
        logic [31:0] e;
        a = ad[4:1];
        v = $urandom;
        e = '0;
        valid = 1;
        lsw = {wr ? 8'hbd : 8'hbf, sel};
        msw = ad;
        cpu_loc = v;
        if (!ad[0] && ad < 16'h18) begin
            if (a < 9) begin
                e = gp[a];
                if (wr) gp[a] = v;
            end else if (a < 11) begin
                e = vt[a - 9];
                if (wr) vt[a - 9] = v;
            end else e = st;
        end
        @(posedge clk);
        #1;
        `VMD_CHK("busy", 1'b1, busy)
        lsw = 16'he204;
        msw = 16'h0000;
        @(posedge clk);
        #1;
        `VMD_CHK("busy", 1'b0, busy)
        `VMD_CHK("dropped", 1'b0, mem_wr)
        `VMD_CHK("loc_wr", !wr, loc_wr)
        if (!wr) begin
            `VMD_CHK("loc_sel", sel, loc_sel)
            `VMD_CHK("loc_data", e, loc_data)
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        stop_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h805a4ccc));
        st = 0;
        vt = '{default: 0};
        gp = '{default: 0};
        for (int i = 0; i < 256; i++) begin
            bm[i] = $urandom;
            host.mem[i] = bm[i];
        end
        repeat (12) @(posedge clk);
        #1;
        rst = 0;
        for (int i = 0; i < 9; i++) op(16'he3f0, {4'h0, 4'(i), 8'(i)});
        for (int n = 0; n < 900; n++) begin
            k = $urandom % 12;
            r = $urandom;
            m = {3'b0, r[16], r[19] ? r[11:8] : {1'b0, r[10:8]}, r[7:0]};
            if (r[20]) m[15:9] = 7'h0;
            if (k == 8 && r[21]) m[15:8] = 8'h02;
            if (k < 9) op(ops[k], m);
            else if (k == 9) begin
                idle(2);
                abs_op(1'b0, r[31:24], {11'h0, r[4:0]});
            end else begin
                abs_op(1'b1, r[31:24], {11'h0, r[4:0]});
                idle(4);
            end
        end
        for (int i = 0; i < 9; i++) op(16'he204, {4'h0, 4'(i), 8'h40});
        op(16'he205, 16'h0041);
        op(16'he205, 16'h0141);
        op(16'he20d, 16'h0042);
        idle(2);
        stop_test();
    end
endmodule
